// File: src/vcd_pkg.sv
/*
 Shared constants for the video crop and decimate front end.
 Assumes a single 40 MHz ref_clk domain; pixel clock arrives as a pin.
*/
package vcd_pkg;
	localparam int PIX_W = 16;
	localparam int CNT_W = 11;
	localparam int LINE_W = 10;
	localparam int DCM_W = 6;
	localparam int SUM_W = 7;
	localparam logic [SUM_W-1:0] DCM_PERIOD = 7'h40;
	localparam int FLT_W = 3;
	localparam logic [FLT_W-1:0] FLT_BYPASS = 3'h0;
	localparam logic [FLT_W-1:0] FLT_TAP3 = 3'h1;
	localparam logic [FLT_W-1:0] FLT_TAP5 = 3'h2;
	localparam logic [FLT_W-1:0] FLT_BINOM5 = 3'h3;
	localparam int FLT_TAPS = 5;
	localparam int FLT_CENTER = 2;
	localparam int SYNC_STAGES = 3;
	localparam int TAG_W = 4;
	localparam int TAG_FWD = 0;
	localparam int TAG_SOL = 1;
	localparam int TAG_SOF = 2;
	localparam int TAG_ODD = 3;
	localparam int FIFO_W = PIX_W + 3;
	localparam int FIFO_DEPTH = 8;
	localparam logic [CNT_W-1:0] PIX_CNT_IDLE = 11'h7FF;
	localparam logic [LINE_W-1:0] LINE_CNT_IDLE = 10'h3FF;
endpackage

// File: src/vcd_fifo.sv
/*
 Parameterised FIFO with valid/ready on both sides.
 Assumes one clock; full and empty follow the fill count exactly.
*/
`timescale 1ns/1ps
`default_nettype none
module vcd_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Sync reset, active low
	input wire logic in_valid, // Write request
	output logic in_ready, // Room for one word
	input wire logic [W-1:0] in_data, // Write word
	output logic out_valid, // Word available
	input wire logic out_ready, // Reader takes word
	output logic [W-1:0] out_data // Head word
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} vcd_fifo_st_t;
	vcd_fifo_st_t s_q, s_d;
	logic wr, rd;

	assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_q.cnt != '0);
	assign out_data = s_q.mem[s_q.rp];

	always_comb begin
		s_d = s_q;
		wr = in_valid && in_ready;
		rd = out_valid && out_ready;
		if (wr) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + AW'(1);
		end
		if (rd) begin
			s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + AW'(1);
		end
		if (wr && !rd) begin
			s_d.cnt = s_q.cnt + (AW+1)'(1);
		end else if (rd && !wr) begin
			s_d.cnt = s_q.cnt - (AW+1)'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
		s_q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count past depth");
endmodule // vcd_fifo
`default_nettype wire

// File: src/vcd_horizontal_filter_select.sv
/*
 Selectable horizontal luma filter over a five pixel window.
 Assumes shift pulses once per pixel; tags ride along with the centre.
*/
`timescale 1ns/1ps
`default_nettype none
module vcd_horizontal_filter_select
	import vcd_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Sync reset, active low
	input wire logic shift, // One pulse per pixel
	input wire logic [FLT_W-1:0] sel, // Filter choice
	input wire logic [PIX_W-1:0] in_data, // Pixel in, Y high byte
	input wire logic [TAG_W-1:0] in_tag, // Flags of pixel in
	output logic out_stb, // One-cycle result strobe
	output logic [PIX_W-1:0] out_data, // Filtered pixel
	output logic [TAG_W-1:0] out_tag // Flags of filtered pixel
);
	typedef struct packed {
		logic [FLT_TAPS-1:0][PIX_W-1:0] win;
		logic [FLT_TAPS-1:0][TAG_W-1:0] tag;
		logic stb;
		logic [PIX_W-1:0] dat;
		logic [TAG_W-1:0] tg;
	} vcd_flt_st_t;
	vcd_flt_st_t s_q, s_d;
	logic [11:0] y [FLT_TAPS];
	logic [11:0] acc;

	always_comb begin
		s_d = s_q;
		s_d.stb = 1'b0;
		for (int i = 0; i < FLT_TAPS; i++) begin
			y[i] = {4'h0, s_q.win[i][15:8]};
		end
		unique case (sel)
			FLT_TAP3: acc = (y[1] + (y[2] << 1) + y[3] + 12'h002) >> 2;
			FLT_TAP5: acc = (y[0] + (y[1] << 1) + (y[2] << 1) + (y[3] << 1)
				+ y[4] + 12'h004) >> 3;
			FLT_BINOM5: acc = (y[0] + (y[1] << 2) + (y[2] << 2) + (y[2] << 1)
				+ (y[3] << 2) + y[4] + 12'h008) >> 4;
			default: acc = y[FLT_CENTER];
		endcase
		if (shift) begin
			s_d.win = {s_q.win[FLT_TAPS-2:0], in_data};
			s_d.tag = {s_q.tag[FLT_TAPS-2:0], in_tag};
			s_d.stb = 1'b1;
			s_d.dat = {acc[7:0], s_q.win[FLT_CENTER][7:0]};
			s_d.tg = s_q.tag[FLT_CENTER];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign out_stb = s_q.stb;
	assign out_data = s_q.dat;
	assign out_tag = s_q.tg;

	a_filter_bypass: assert property (
		@(posedge clk) disable iff (!rst_n)
		shift && sel == FLT_BYPASS |=> out_data == $past(s_q.win[FLT_CENTER]))
		else $error("bypass filter altered the pixel");
endmodule // vcd_horizontal_filter_select
`default_nettype wire

// File: src/vcd_front.sv
/*
 Video input crop and decimate front end: windowing, drop-out-of-64
 decimation, horizontal filter and an output FIFO.
 Assumes pixel clock, syncs and YUV data arrive from an external decoder,
 all asynchronous to ref_clk and much slower than it.
*/
// Summary of operation
// - Pixels are captured from the first-pixel count to the last-pixel count after the active hsync edge, giving last minus first plus 1 pixels.
// - Lines are captured from the first-line count to the last-line count after the active vsync edge in each field.
// - Each sync input has its own polarity setting that picks its active edge.
// - Exactly the horizontal drop count of every 64 captured pixels in a line is discarded.
// - Exactly the vertical drop count of every 64 captured lines in a field is discarded.
// - Captured pixels pass through the horizontal filter chosen by the filter select.
// - Layout 1 shows a single field (odd fields dropped), layout 0 emulates interlace with every field passed.
// - The block only removes pixels and lines, so the output never exceeds the sampled input.
`timescale 1ns/1ps
`default_nettype none
module vcd_front
	import vcd_pkg::*;
(
	input wire logic ref_clk, // 40 MHz clock
	input wire logic rst_n, // Sync reset, active low
	input wire logic pix_clk, // Decoder pixel clock pin
	input wire logic hsync, // Horizontal sync pin
	input wire logic vsync, // Vertical sync pin
	input wire logic [PIX_W-1:0] pix_data, // YUV 4:2:2 pins, Y high
	input wire logic horizontal_sync_polarity, // 1: hsync active high
	input wire logic vertical_sync_polarity, // 1: vsync active high
	input wire logic [CNT_W-1:0] line_sample_first, // First pixel count
	input wire logic [CNT_W-1:0] line_sample_last, // Last pixel count
	input wire logic [LINE_W-1:0] field_line_first, // First line count
	input wire logic [LINE_W-1:0] field_line_last, // Last line count
	input wire logic [DCM_W-1:0] horizontal_drop_count, // Pixels dropped per 64
	input wire logic [DCM_W-1:0] vertical_drop_count, // Lines dropped per 64
	input wire logic [FLT_W-1:0] horizontal_filter_select, // Filter choice
	input wire logic display_layout_select, // 1 single field, 0 interlaced
	input wire logic overflow_clear, // Clears overflow flag
	input wire logic out_ready, // Downstream takes pixel
	output logic out_valid, // Pixel available
	output logic [PIX_W-1:0] out_data, // Output pixel
	output logic out_line_start, // First pixel of a line
	output logic out_field_start, // First pixel of a field
	output logic out_field_odd, // Field parity of pixel
	output logic overflow // Sticky: FIFO refused a pixel
);
	typedef struct packed {
		logic [SYNC_STAGES-1:0] ck_s;
		logic [SYNC_STAGES-1:0] hs_s;
		logic [SYNC_STAGES-1:0] vs_s;
		logic [SYNC_STAGES-1:0][PIX_W-1:0] dt_s;
		logic ck_lvl;
		logic hs_prev;
		logic vs_prev;
		logic [CNT_W-1:0] pix_cnt;
		logic [LINE_W-1:0] line_cnt;
		logic [DCM_W-1:0] hacc;
		logic [DCM_W-1:0] vacc;
		logic line_keep;
		logic sol_pend;
		logic sof_pend;
		logic field_odd;
		logic o_valid;
		logic [PIX_W-1:0] o_data;
		logic o_sol;
		logic o_sof;
		logic o_odd;
		logic ovf;
	} vcd_front_st_t;

	vcd_front_st_t s_q, s_d;
	logic tick, hs_act, vs_act, hs_edge, vs_edge, cap_h, hkeep, fwd;
	logic [SUM_W-1:0] hsum, vsum;
	logic [LINE_W-1:0] lbase;
	logic [TAG_W-1:0] tag_in, ft_tag;
	logic ft_stb, f_in_valid, f_in_ready, f_out_valid, f_rd;
	logic [PIX_W-1:0] ft_data;
	logic [FIFO_W-1:0] f_out_data;

	function automatic logic in_range(input logic [CNT_W-1:0] v,
		input logic [CNT_W-1:0] lo, input logic [CNT_W-1:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	function automatic logic [SUM_W-1:0] dcm_sum(input logic [DCM_W-1:0] a,
		input logic [DCM_W-1:0] b);
		dcm_sum = {1'b0, a} + {1'b0, b};
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.ck_s = {s_q.ck_s[SYNC_STAGES-2:0], pix_clk};
		s_d.hs_s = {s_q.hs_s[SYNC_STAGES-2:0], hsync};
		s_d.vs_s = {s_q.vs_s[SYNC_STAGES-2:0], vsync};
		s_d.dt_s = {s_q.dt_s[SYNC_STAGES-2:0], pix_data};
		// Pixel clock level changes once stages two and three agree
		if (s_q.ck_s[1] == s_q.ck_s[2]) begin
			s_d.ck_lvl = s_q.ck_s[2];
		end
		tick = (s_q.ck_s[1] == s_q.ck_s[2]) && s_q.ck_s[2] && !s_q.ck_lvl;
		hs_act = s_q.hs_s[2] ~^ horizontal_sync_polarity;
		vs_act = s_q.vs_s[2] ~^ vertical_sync_polarity;
		hs_edge = tick && hs_act && !s_q.hs_prev;
		vs_edge = tick && vs_act && !s_q.vs_prev;
		lbase = vs_edge ? '0 : s_q.line_cnt;
		vsum = dcm_sum(vs_edge ? '0 : s_q.vacc, vertical_drop_count);
		cap_h = 1'b0;
		hkeep = 1'b0;
		hsum = '0;
		fwd = 1'b0;
		tag_in = '0;
		if (tick) begin
			s_d.hs_prev = hs_act;
			s_d.vs_prev = vs_act;
			if (vs_edge) begin
				s_d.line_cnt = '0;
				s_d.vacc = '0;
				s_d.line_keep = 1'b0;
				s_d.field_odd = !s_q.field_odd;
				s_d.sof_pend = 1'b1;
			end
			if (hs_edge) begin
				s_d.pix_cnt = '0;
				s_d.hacc = '0;
				s_d.sol_pend = 1'b1;
				if (lbase != LINE_CNT_IDLE) begin
					s_d.line_cnt = lbase + LINE_W'(1);
				end
				s_d.line_keep = 1'b0;
				if (in_range(CNT_W'(s_d.line_cnt), CNT_W'(field_line_first),
					CNT_W'(field_line_last))) begin
					s_d.line_keep = (vsum < DCM_PERIOD);
					s_d.vacc = (vsum < DCM_PERIOD) ? vsum[DCM_W-1:0]
						: DCM_W'(vsum - DCM_PERIOD);
				end
			end else if (s_q.pix_cnt != PIX_CNT_IDLE) begin
				s_d.pix_cnt = s_q.pix_cnt + CNT_W'(1);
			end
			cap_h = in_range(s_d.pix_cnt, line_sample_first,
				line_sample_last);
			hsum = dcm_sum(hs_edge ? '0 : s_q.hacc, horizontal_drop_count);
			if (cap_h) begin
				hkeep = (hsum < DCM_PERIOD);
				s_d.hacc = hkeep ? hsum[DCM_W-1:0]
					: DCM_W'(hsum - DCM_PERIOD);
			end
			// Drop only, never repeat: output stays within the input
			fwd = cap_h && hkeep && s_d.line_keep
				&& !(display_layout_select && s_d.field_odd);
			tag_in[TAG_FWD] = fwd;
			tag_in[TAG_SOL] = fwd && s_d.sol_pend;
			tag_in[TAG_SOF] = fwd && s_d.sof_pend;
			tag_in[TAG_ODD] = s_d.field_odd;
			if (fwd) begin
				s_d.sol_pend = 1'b0;
				s_d.sof_pend = 1'b0;
			end
		end
		// Overflow: set wins over clear
		f_in_valid = ft_stb && ft_tag[TAG_FWD];
		if (f_in_valid && !f_in_ready) begin
			s_d.ovf = 1'b1;
		end else if (overflow_clear) begin
			s_d.ovf = 1'b0;
		end
		// Output register fed in order from the FIFO head
		f_rd = !s_q.o_valid || out_ready;
		if (f_rd) begin
			s_d.o_valid = f_out_valid;
			if (f_out_valid) begin
				s_d.o_data = f_out_data[PIX_W-1:0];
				s_d.o_sol = f_out_data[PIX_W];
				s_d.o_sof = f_out_data[PIX_W+1];
				s_d.o_odd = f_out_data[PIX_W+2];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.pix_cnt <= PIX_CNT_IDLE;
			s_q.line_cnt <= LINE_CNT_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	vcd_horizontal_filter_select u_filter (
		.clk(ref_clk),
		.rst_n(rst_n),
		.shift(tick),
		.sel(horizontal_filter_select),
		.in_data(s_q.dt_s[2]),
		.in_tag(tag_in),
		.out_stb(ft_stb),
		.out_data(ft_data),
		.out_tag(ft_tag)
	);

	vcd_fifo #(
		.W(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(f_in_valid),
		.in_ready(f_in_ready),
		.in_data({ft_tag[TAG_ODD], ft_tag[TAG_SOF], ft_tag[TAG_SOL], ft_data}),
		.out_valid(f_out_valid),
		.out_ready(f_rd),
		.out_data(f_out_data)
	);

	assign out_valid = s_q.o_valid;
	assign out_data = s_q.o_data;
	assign out_line_start = s_q.o_sol;
	assign out_field_start = s_q.o_sof;
	assign out_field_odd = s_q.o_odd;
	assign overflow = s_q.ovf;

	// Checks
	a_pix_window: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		tick && tag_in[TAG_FWD] |-> s_d.pix_cnt >= line_sample_first
		&& s_d.pix_cnt <= line_sample_last)
		else $error("pixel forwarded outside pixel window");

	a_tick_single: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		tick |=> !tick)
		else $error("one pixel clock edge counted twice");

	a_line_window: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		tick && tag_in[TAG_FWD] |-> s_d.line_cnt >= field_line_first
		&& s_d.line_cnt <= field_line_last)
		else $error("pixel forwarded outside line window");

	a_line_outside: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		hs_edge && !in_range(CNT_W'(s_d.line_cnt),
		CNT_W'(field_line_first), CNT_W'(field_line_last))
		|=> !s_q.line_keep)
		else $error("line kept outside line window");

	a_hsync_edge: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		tick && (s_q.hs_s[2] ~^ horizontal_sync_polarity) && !s_q.hs_prev
		|=> s_q.pix_cnt == '0 && (s_q.sol_pend || $past(fwd)))
		else $error("active hsync edge did not restart the line");

	a_vsync_edge: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		vs_edge && !hs_edge |=> s_q.line_cnt == '0 && s_q.vacc == '0
		&& !s_q.line_keep)
		else $error("active vsync edge did not restart the field");

	a_hdrop_rate: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		tick && cap_h && hsum >= DCM_PERIOD |-> !tag_in[TAG_FWD] ##1
		s_q.hacc == $past(hsum[DCM_W-1:0]))
		else $error("horizontal drop decision wrong");

	a_vdrop_rate: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		hs_edge && s_d.line_keep |-> vsum < DCM_PERIOD ##1
		s_q.vacc == $past(vsum[DCM_W-1:0]))
		else $error("vertical drop decision wrong");

	a_layout_single: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		display_layout_select && s_d.field_odd |-> !tag_in[TAG_FWD])
		else $error("odd field forwarded in single field layout");

	a_field_parity: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		vs_edge |=> s_q.field_odd != $past(s_q.field_odd))
		else $error("field parity did not toggle");

	a_out_hold: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		out_valid && !out_ready |=> out_valid && $stable(out_data)
		&& $stable(out_line_start))
		else $error("output changed while stalled");

	a_sof_on_sol: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		out_valid && out_field_start |-> out_line_start)
		else $error("field start without line start");

	a_ovf_sticky: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		f_in_valid && !f_in_ready |=> overflow
		##1 (overflow || $past(overflow_clear)))
		else $error("refused pixel not flagged");

	a_ovf_clear: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		overflow_clear && !(f_in_valid && !f_in_ready) |=> !overflow)
		else $error("overflow not cleared");

	a_no_upscale: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		f_in_valid |-> $past(tick))
		else $error("pixel produced without an input pixel");

	c_line_start: cover property (@(posedge ref_clk) disable iff (!rst_n)
		out_valid && out_ready && out_line_start);
	c_field_start: cover property (@(posedge ref_clk) disable iff (!rst_n)
		out_valid && out_ready && out_field_start);
	c_hdrop: cover property (@(posedge ref_clk) disable iff (!rst_n)
		tick && cap_h && !hkeep);
	c_overflow: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(overflow));
	c_odd_drop: cover property (@(posedge ref_clk) disable iff (!rst_n)
		tick && cap_h && display_layout_select && s_d.field_odd);
endmodule // vcd_front
`default_nettype wire

// File: dv/vcd_decoder_model.sv
/*
 Behavioural video decoder: sends one field per start request.
 Assumes ref_clk as time base; pixel clock stands still between fields.
*/
`timescale 1ns/1ps
`default_nettype none
module vcd_decoder_model #(
	parameter int PIX = 64, // Pixels per line
	parameter int LINES = 10 // Lines per field
) (
	input wire logic ref_clk, // Time base
	input wire logic start, // Send one field
	input wire logic hpol, // 1: hsync active high
	input wire logic vpol, // 1: vsync active high
	input wire logic [15:0] rnd, // Random pixel source
	output logic pix_clk, // Pixel clock pin
	output logic hsync, // Horizontal sync pin
	output logic vsync, // Vertical sync pin
	output logic [15:0] pix_data, // Pixel pins
	output logic busy, // Field in progress
	output logic mon_stb, // Pixel clock rose
	output int mon_line, // Line of pixel, 0 holds vsync
	output int mon_pix // Pixel count from sync edge
);
	int ph = 0;
	initial begin
		{busy, mon_stb, pix_clk, hsync, vsync} = 5'h00;
		pix_data = 16'h0000;
		mon_line = 0;
		mon_pix = 0;
	end
	// Hsync active for the first four pixels of lines 1 on, vsync for those of line 0
	task automatic put(input int l, input int p);
		hsync <= (l > 0 && p < 4) ? hpol : ~hpol;
		vsync <= (l == 0 && p < 4) ? vpol : ~vpol;
		pix_data <= rnd;
		mon_line <= l;
		mon_pix <= p;
	endtask
	always @(posedge ref_clk) begin
		mon_stb <= 1'h0;
		if (!busy) begin
			pix_clk <= 1'h0;
			ph <= 0;
			if (start) begin
				busy <= 1'h1;
				put(0, 0);
			end else begin
				hsync <= ~hpol;
				vsync <= ~vpol;
				pix_data <= rnd;
			end
		end else begin
			ph <= (ph + 1) % 8;
			if (ph == 0) begin
				pix_clk <= 1'h1;
				mon_stb <= 1'h1;
			end
			if (ph == 4) begin
				pix_clk <= 1'h0;
				if (mon_pix < PIX - 1) put(mon_line, mon_pix + 1);
				else if (mon_line < LINES) put(mon_line + 1, 0);
				else busy <= 1'h0;
			end
		end
	end
endmodule // vcd_decoder_model
`default_nettype wire

// File: dv/vcd_front_test.sv
/*
 Self-checking bench for the crop and decimate front end.
 Assumes the decoder model as pixel source and a queue model of output.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	errors++; \
	$display("mismatch %s expected %0h seen %0h", nm, e, g); \
end end
module vcd_front_test;
	import vcd_pkg::*;
	typedef struct {int l; int p; int s; logic ls; logic fs; logic odd;} vcd_exp_t;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic start = 1'h0;
	logic hold = 1'h0;
	logic hpol = 1'h1;
	logic vpol = 1'h1;
	logic lay = 1'h0;
	logic ovf_clr = 1'h0;
	logic out_ready = 1'h0;
	logic [15:0] rnd = 16'h0000;
	logic [CNT_W-1:0] hf = 11'h002;
	logic [CNT_W-1:0] hl = 11'h002;
	logic [LINE_W-1:0] vf = 10'h001;
	logic [LINE_W-1:0] vl = 10'h001;
	logic [DCM_W-1:0] hd = 6'h00;
	logic [DCM_W-1:0] vd = 6'h00;
	logic [FLT_W-1:0] sel = 3'h0;
	logic pix_clk, hsync, vsync, busy, mon_stb;
	logic out_valid, out_line_start, out_field_start, out_field_odd, overflow;
	logic [15:0] pix_data;
	logic [PIX_W-1:0] out_data;
	int mon_line, mon_pix, vacc, hacc;
	int seed = 32'h6976;
	int errors = 0;
	int n_checks = 0;
	int n_out = 0;
	int n_exp = 0;
	logic par = 1'h0;
	logic ls_p, fs_p, keepl;
	vcd_exp_t q[$];
	logic [15:0] pmem [0:10][0:63];

	initial forever #12.5 ref_clk = ~ref_clk;

	vcd_decoder_model i_vcd_decoder_model (.ref_clk(ref_clk), .start(start),
		.hpol(hpol), .vpol(vpol), .rnd(rnd), .pix_clk(pix_clk),
		.hsync(hsync), .vsync(vsync), .pix_data(pix_data), .busy(busy),
		.mon_stb(mon_stb), .mon_line(mon_line), .mon_pix(mon_pix));

	vcd_front i_vcd_front (.ref_clk(ref_clk), .rst_n(rst_n),
		.pix_clk(pix_clk), .hsync(hsync), .vsync(vsync), .pix_data(pix_data),
		.horizontal_sync_polarity(hpol), .vertical_sync_polarity(vpol),
		.line_sample_first(hf), .line_sample_last(hl),
		.field_line_first(vf), .field_line_last(vl),
		.horizontal_drop_count(hd), .vertical_drop_count(vd),
		.horizontal_filter_select(sel), .display_layout_select(lay),
		.overflow_clear(ovf_clr), .out_ready(out_ready),
		.out_valid(out_valid), .out_data(out_data),
		.out_line_start(out_line_start), .out_field_start(out_field_start),
		.out_field_odd(out_field_odd), .overflow(overflow));

	always @(posedge ref_clk) begin
		rnd <= 16'($random(seed));
		out_ready <= !hold && ($random(seed) % 4 != 0);
	end

	function automatic int fy(vcd_exp_t e);
		int w[5];
		int d;
		int s;
		case (e.s)
			1: begin w = '{0, 1, 2, 1, 0}; d = 4; end
			2: begin w = '{1, 2, 2, 2, 1}; d = 8; end
			3: begin w = '{1, 4, 6, 4, 1}; d = 16; end
			default: begin w = '{0, 0, 1, 0, 0}; d = 1; end
		endcase
		s = 0;
		for (int k = 0; k < 5; k++) s += w[k] * pmem[e.l][e.p - 2 + k][15:8];
		return (s + d / 2) / d;
	endfunction

	// Reference of windowing and drop-out-of-64 per pixel sent
	always @(posedge ref_clk) begin : model
		int s;
		if (mon_stb) begin
			pmem[mon_line][mon_pix] = pix_data;
			if (mon_pix == 0 && mon_line == 0) begin
				par = ~par;
				vacc = 0;
				fs_p = 1'h1;
			end
			if (mon_pix == 0 && mon_line > 0) begin
				hacc = 0;
				ls_p = 1'h1;
				keepl = 1'h0;
				if (mon_line >= vf && mon_line <= vl) begin
					s = vacc + vd;
					keepl = s < 64;
					vacc = keepl ? s : s - 64;
				end
			end
			if (mon_line > 0 && mon_pix >= hf && mon_pix <= hl) begin
				s = hacc + hd;
				if (s < 64 && keepl && !(lay && par)) begin
					q.push_back('{mon_line, mon_pix, sel, ls_p, fs_p, par});
					ls_p = 1'h0;
					fs_p = 1'h0;
					n_exp++;
				end
				hacc = s < 64 ? s : s - 64;
			end
		end
	end

	always @(posedge ref_clk) begin : mon
		vcd_exp_t e;
		logic [15:0] xd;
		if (rst_n && out_valid && out_ready) begin
			n_out++;
			if (q.size() == 0) `CHK("extra pixel", 0, 1)
			else begin
				e = q.pop_front();
				xd = 16'((fy(e) << 8) | pmem[e.l][e.p][7:0]);
				`CHK("out_data", xd, out_data)
				`CHK("line_start", e.ls, out_line_start)
				`CHK("field_start", e.fs, out_field_start)
				`CHK("field_odd", e.odd, out_field_odd)
			end
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic run_field();
		int c;
		n_out = 0;
		n_exp = 0;
		@(posedge ref_clk) start <= 1'h1;
		@(posedge ref_clk) start <= 1'h0;
		c = 0;
		while (c < 9000 && (c < 2 || busy)) begin
			@(posedge ref_clk);
			c++;
		end
		`CHK("field end", 1'h0, busy)
		c = 0;
		while (c < 400 && (hold ? c < 20 : q.size() > 0)) begin
			@(posedge ref_clk);
			c++;
		end
		if (!hold) `CHK("queue drained", 0, q.size())
	endtask

	initial begin
		repeat (100000) @(posedge ref_clk);
		errors++;
		print_verdict();
	end

	initial begin : main
		int r;
		int c;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			hpol <= i[0];
			vpol <= i[1];
			sel <= FLT_W'(i);
			hf <= CNT_W'(2 + r[2:0]);
			hl <= CNT_W'(2 + r[2:0] + (i == 1 ? 0 : r[8:3] % 50));
			vf <= LINE_W'(1 + r[10:9]);
			vl <= LINE_W'(1 + r[10:9] + (i == 1 ? 0 : r[13:11] % 7));
			hd <= (i == 0) ? 6'h00 : (i == 2) ? 6'h3F : r[21:16];
			vd <= (i == 0) ? 6'h00 : (i == 2) ? 6'h3F : r[27:22];
			run_field();
			if (i < 2) `CHK("window size", (hl - hf + 1) * (vl - vf + 1), n_out)
		end
		lay <= 1'h1;
		run_field();
		`CHK("odd field count", 0, n_out)
		run_field();
		`CHK("even field count", n_exp, n_out)
		lay <= 1'h0;
		hold <= 1'h1;
		hf <= 11'h002;
		hl <= 11'h03A;
		vf <= 10'h001;
		vl <= 10'h00A;
		hd <= 6'h00;
		vd <= 6'h00;
		run_field();
		`CHK("overflow", 1'h1, overflow)
		hold <= 1'h0;
		c = 0;
		while (c < 300 && (c < 5 || out_valid)) begin
			@(posedge ref_clk);
			c++;
		end
		`CHK("output idle", 1'h0, out_valid)
		`CHK("drained", 1'h1, n_out >= FIFO_DEPTH)
		q.delete();
		ovf_clr <= 1'h1;
		@(posedge ref_clk) ovf_clr <= 1'h0;
		repeat (2) @(posedge ref_clk);
		`CHK("overflow clear", 1'h0, overflow)
		print_verdict();
	end
endmodule // vcd_front_test
`default_nettype wire
